// >>> hw/wtvpc_pkg.sv
// Package: constants, register map and states of the inverter voltage loop
// Overview of operation
// - Fixed variant drives the inverter at a constant 140 kHz, never steered.
// - Power is set by inverter input voltage 3 to 12 V; lower means less.
// - Voltage command steps 0.5 mV, well inside 50 mV resolution.
// - Fixed variant starts every ping at 8 V.
// - A PID loop drives the voltage command.
// - Coil voltage amplitude is captured at 1 mV resolution.
// - Proportional gain 1 per mA, integral and derivative gains zero.
// - PID output clamped to 1500, each unit lowers voltage by 0.5 mV.
// - Variable variant keeps frequency within 105 to 140 kHz.
// - Variable variant starts every ping at 6 V.
// - Variable variant first applies power at 140 kHz.
// - No acceptable signal strength packet in time removes the power signal.
// - Retries follow at successively lower frequency until a good packet arrives or the 105 kHz edge has been tried.
// - Dual coil mode tries upper then lower coil before moving on.
// - Exactly one coil switch is closed at every moment.
`default_nettype none
package wtvpc_pkg;
  // APB byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SSMIN  = 8'h04;
  localparam logic [7:0] OFF_STEP   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_VCMD   = 8'h10;
  localparam logic [7:0] OFF_FREQ   = 8'h14;
  localparam logic [7:0] OFF_COILMV = 8'h18;
  // Field positions
  localparam int CTRL_EN   = 0;
  localparam int CTRL_VAR  = 1;
  localparam int CTRL_DUAL = 2;
  localparam int STAT_FAIL = 3;
  // Reset values
  localparam logic [7:0] SSMIN_RST = 8'h01;
  localparam logic [7:0] STEP_RST  = 8'h05;
  // Voltage command in 0.5 mV units: 6000, 24000, 16000, 12000
  localparam logic [14:0] V_MIN      = 15'h1770;
  localparam logic [14:0] V_MAX      = 15'h5dc0;
  localparam logic [14:0] V_PING_FIX = 15'h3e80;
  localparam logic [14:0] V_PING_VAR = 15'h2ee0;
  // PID gain and output limit (1500)
  localparam logic signed [15:0] KP      = 16'sh0001;
  localparam logic signed [16:0] PID_LIM = 17'sh005dc;
  // Frequencies in kHz: 140 and 105
  localparam logic [7:0] F_FIX = 8'h8c;
  localparam logic [7:0] F_MIN = 8'h69;
  // Phase increment per kHz at 125 MHz: 2^32 / 125000
  localparam logic [31:0] KHZ_WORD = 32'h00008638;
  // Timing
  localparam logic [31:0] CLK_KHZ = 32'h0001e848;
  localparam logic [31:0] PING_MS = 32'h00000046;
  localparam logic [31:0] OFF_MS  = 32'h00000014;
  // Sequencer states
  typedef enum logic [1:0] {st_idle, st_ping, st_off, st_xfer} wtvpc_state_e;
endpackage : wtvpc_pkg
`default_nettype wire

// >>> hw/wtvpc_top.sv
// Module: ping sequencer, PID voltage loop and APB registers of the transmitter
`default_nettype none
module wtvpc_top #(
  parameter logic [31:0] PING_CYC = wtvpc_pkg::PING_MS * wtvpc_pkg::CLK_KHZ,
  parameter logic [31:0] OFF_CYC  = wtvpc_pkg::OFF_MS * wtvpc_pkg::CLK_KHZ
) (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  // APB slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // Packet decoder results
  input  wire logic               ss_valid_i,
  input  wire logic [7:0]         ss_value_i,
  input  wire logic               err_valid_i,
  input  wire logic signed [15:0] err_ma_i,
  input  wire logic               xfer_end_i,
  // Coil voltage sense, 1 mV per count
  input  wire logic               adc_valid_i,
  input  wire logic [15:0]        adc_mv_i,
  // Power stage
  output logic                    power_en_o,
  output logic                    drive_o,
  output logic      [14:0]        vcmd_o,
  output logic      [7:0]         freq_khz_o,
  output logic                    upper_coil_switch_o,
  output logic                    lower_coil_switch_o
);

  wtvpc_pkg::wtvpc_state_e state_q;
  logic [2:0]  ctrl_q;
  logic [7:0]  ssmin_q;
  logic [7:0]  step_q;
  logic [31:0] tmr_q;
  logic [7:0]  freq_q;
  logic        coil_q;
  logic        fail_q;
  logic [14:0] vcmd_q;
  logic [15:0] coil_mv_q;
  logic [31:0] acc_q;
  logic        drive_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  logic        en;
  logic        var_mode;
  logic        dual;
  logic        wr_en;
  logic        setup;
  logic        ss_ok;
  logic        tmr_done;
  logic        last_coil;
  logic        at_edge;
  logic        exhausted;
  logic        go_ping;
  logic        fail_set;
  logic        fail_clr;
  logic [8:0]  f_floor;
  logic [7:0]  f_next;
  logic [31:0] rd_mux;
  logic        rd_err;

  // Control register fields
  assign en       = ctrl_q[wtvpc_pkg::CTRL_EN];
  assign var_mode = ctrl_q[wtvpc_pkg::CTRL_VAR];
  assign dual     = ctrl_q[wtvpc_pkg::CTRL_DUAL];

  // Zero wait states, so the setup cycle prepares read data
  assign setup    = psel_i && !penable_i;
  assign wr_en    = psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;

  // Read decode; unmapped offsets answer zero with an error
  always_comb begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    unique case (paddr_i)
      wtvpc_pkg::OFF_CTRL:   rd_mux = {29'h0, ctrl_q};
      wtvpc_pkg::OFF_SSMIN:  rd_mux = {24'h0, ssmin_q};
      wtvpc_pkg::OFF_STEP:   rd_mux = {24'h0, step_q};
      wtvpc_pkg::OFF_STATUS: rd_mux = {28'h0, fail_q, coil_q, state_q};
      wtvpc_pkg::OFF_VCMD:   rd_mux = {17'h0, vcmd_q};
      wtvpc_pkg::OFF_FREQ:   rd_mux = {24'h0, freq_q};
      wtvpc_pkg::OFF_COILMV: rd_mux = {16'h0, coil_mv_q};
      default:               rd_err = 1'b1;
    endcase
  end

  // Read data and error latched in the setup cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite_i ? 32'h0 : rd_mux;
      pslverr_q <= rd_err;
    end
  end
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q;

  // Software writable registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q  <= 3'h0;
      ssmin_q <= wtvpc_pkg::SSMIN_RST;
      step_q  <= wtvpc_pkg::STEP_RST;
    end else if (wr_en) begin
      if (paddr_i == wtvpc_pkg::OFF_CTRL) ctrl_q <= pwdata_i[2:0];
      if (paddr_i == wtvpc_pkg::OFF_SSMIN) ssmin_q <= pwdata_i[7:0];
      if (paddr_i == wtvpc_pkg::OFF_STEP) step_q <= pwdata_i[7:0];
    end
  end

  // Ping bookkeeping
  assign ss_ok     = ss_valid_i && (ss_value_i >= ssmin_q);
  assign tmr_done  = (tmr_q == 32'h0);
  assign last_coil = !dual || coil_q;
  assign at_edge   = !var_mode || (freq_q <= wtvpc_pkg::F_MIN);
  assign exhausted = last_coil && at_edge;
  assign f_floor   = {1'b0, wtvpc_pkg::F_MIN} + {1'b0, step_q};
  // Clamp at the band edge so a large step cannot skip below it
  assign f_next    = ({1'b0, freq_q} > f_floor) ? (freq_q - step_q)
                                                : wtvpc_pkg::F_MIN;
  assign go_ping   = en && ((state_q == wtvpc_pkg::st_idle && !fail_q) ||
                     (state_q == wtvpc_pkg::st_off && tmr_done && !exhausted));
  assign fail_set  = en && state_q == wtvpc_pkg::st_off && tmr_done && exhausted;
  assign fail_clr  = wr_en && paddr_i == wtvpc_pkg::OFF_STATUS &&
                     pwdata_i[wtvpc_pkg::STAT_FAIL];

  // Sequencer: ping, remove, retry, transfer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= wtvpc_pkg::st_idle;
      tmr_q   <= 32'h0;
      freq_q  <= wtvpc_pkg::F_FIX;
      coil_q  <= 1'b0;
    end else begin
      if (!tmr_done) tmr_q <= tmr_q - 32'h1;
      unique case (state_q)
        wtvpc_pkg::st_idle: begin
          if (go_ping) begin
            state_q <= wtvpc_pkg::st_ping;
            tmr_q   <= PING_CYC;
            freq_q  <= wtvpc_pkg::F_FIX;
            coil_q  <= 1'b0;
          end
        end
        wtvpc_pkg::st_ping: begin
          if (!en) begin
            state_q <= wtvpc_pkg::st_idle;
          end else if (ss_ok) begin
            state_q <= wtvpc_pkg::st_xfer;
          end else if (ss_valid_i || tmr_done) begin
            state_q <= wtvpc_pkg::st_off;
            tmr_q   <= OFF_CYC;
          end
        end
        wtvpc_pkg::st_off: begin
          if (!en || exhausted && tmr_done) begin
            state_q <= wtvpc_pkg::st_idle;
            coil_q  <= 1'b0;
          end else if (go_ping) begin
            state_q <= wtvpc_pkg::st_ping;
            tmr_q   <= PING_CYC;
            if (!last_coil) begin
              coil_q <= 1'b1;
            end else begin
              coil_q <= 1'b0;
              freq_q <= f_next;
            end
          end
        end
        wtvpc_pkg::st_xfer: begin
          if (!en || xfer_end_i) state_q <= wtvpc_pkg::st_idle;
        end
      endcase
    end
  end

  // Exhaustion flag; a new failure outranks a software clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) fail_q <= 1'b0;
    else if (fail_set) fail_q <= 1'b1;
    else if (fail_clr) fail_q <= 1'b0;
  end

  // PID: proportional only, output clamped, scaled to 0.5 mV units
  logic signed [31:0] pid_raw;
  logic signed [16:0] pid_c;
  logic signed [17:0] v_sum;
  logic        [14:0] v_sat;
  assign pid_raw = err_ma_i * wtvpc_pkg::KP;
  always_comb begin
    if (pid_raw > wtvpc_pkg::PID_LIM) pid_c = wtvpc_pkg::PID_LIM;
    else if (pid_raw < -wtvpc_pkg::PID_LIM) pid_c = -wtvpc_pkg::PID_LIM;
    else pid_c = pid_raw[16:0];
    // One PID unit is -0.5 mV, exactly one command count
    v_sum = $signed({3'b000, vcmd_q}) - $signed({pid_c[16], pid_c});
    if (v_sum < $signed({3'b000, wtvpc_pkg::V_MIN})) v_sat = wtvpc_pkg::V_MIN;
    else if (v_sum > $signed({3'b000, wtvpc_pkg::V_MAX})) v_sat = wtvpc_pkg::V_MAX;
    else v_sat = v_sum[14:0];
  end

  // Voltage command: reload at each ping, loop update during transfer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) vcmd_q <= wtvpc_pkg::V_PING_FIX;
    else if (go_ping) vcmd_q <= var_mode ? wtvpc_pkg::V_PING_VAR
                                         : wtvpc_pkg::V_PING_FIX;
    else if (state_q == wtvpc_pkg::st_xfer && err_valid_i) vcmd_q <= v_sat;
  end

  // Coil voltage amplitude capture
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) coil_mv_q <= 16'h0;
    else if (adc_valid_i) coil_mv_q <= adc_mv_i;
  end

  // Phase accumulator; 1 kHz word rounding keeps error under 0.01 percent
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q   <= 32'h0;
      drive_q <= 1'b0;
    end else begin
      acc_q   <= acc_q + {24'h0, freq_q} * wtvpc_pkg::KHZ_WORD;
      drive_q <= power_en_o && acc_q[31];
    end
  end

  assign power_en_o          = (state_q == wtvpc_pkg::st_ping) ||
                               (state_q == wtvpc_pkg::st_xfer);
  assign drive_o             = drive_q;
  assign vcmd_o              = vcmd_q;
  assign freq_khz_o          = freq_q;
  // Complementary drive, so never zero or two coils
  assign upper_coil_switch_o = !coil_q;
  assign lower_coil_switch_o = coil_q;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  vcmd_range_a: assert property (vcmd_q >= wtvpc_pkg::V_MIN && vcmd_q <= wtvpc_pkg::V_MAX)
    else $error("voltage command out of range");
  one_coil_a: assert property (upper_coil_switch_o != lower_coil_switch_o)
    else $error("coil switches not exclusive");
  ping_volt_a: assert property (go_ping |=> vcmd_q == ($past(var_mode) ?
    wtvpc_pkg::V_PING_VAR : wtvpc_pkg::V_PING_FIX))
    else $error("wrong ping voltage");
  fixed_freq_a: assert property (!var_mode && state_q == wtvpc_pkg::st_ping
    |-> freq_q == wtvpc_pkg::F_FIX)
    else $error("fixed variant off 140 kHz");
  freq_band_a: assert property (freq_q >= wtvpc_pkg::F_MIN && freq_q <= wtvpc_pkg::F_FIX)
    else $error("frequency outside band");
  pid_limit_a: assert property (state_q == wtvpc_pkg::st_xfer && err_valid_i && !go_ping
    |=> (vcmd_q <= $past(vcmd_q) + 15'h05dc) && (vcmd_q + 15'h05dc >= $past(vcmd_q)))
    else $error("voltage step beyond limit");
  pid_dir_a: assert property (state_q == wtvpc_pkg::st_xfer && err_valid_i &&
    err_ma_i > 16'sh0 && vcmd_q > wtvpc_pkg::V_MIN |=> vcmd_q < $past(vcmd_q))
    else $error("positive error did not lower voltage");
  ping_drop_a: assert property (state_q == wtvpc_pkg::st_ping && !ss_valid_i && tmr_done
    && en |=> !power_en_o [*2])
    else $error("unanswered ping kept power");
  retry_lower_a: assert property (state_q == wtvpc_pkg::st_off && go_ping
    |=> freq_q <= $past(freq_q) && power_en_o)
    else $error("retry frequency rose");
  first_freq_a: assert property (state_q == wtvpc_pkg::st_idle && go_ping
    |=> freq_q == wtvpc_pkg::F_FIX && !coil_q)
    else $error("first ping not at 140 kHz");
  coil_try_a: assert property (state_q == wtvpc_pkg::st_off && go_ping && dual && !coil_q
    |=> coil_q && $stable(freq_q))
    else $error("lower coil not tried");
  // Bridge silence, retry stop and command resolution
  drive_off_a: assert property (!power_en_o |=> !drive_o)
    else $error("bridge driven without power");
  good_packet_a: assert property (state_q == wtvpc_pkg::st_ping && en && ss_ok
    |=> state_q == wtvpc_pkg::st_xfer && power_en_o)
    else $error("good packet did not stop retries");
  edge_stop_a: assert property (fail_set |=> fail_q && state_q == wtvpc_pkg::st_idle)
    else $error("retries went on past the band edge");
  fine_step_a: assert property (state_q == wtvpc_pkg::st_xfer && err_valid_i &&
    err_ma_i == 16'sh0001 && vcmd_q > wtvpc_pkg::V_MIN
    |=> vcmd_q == $past(vcmd_q) - 15'h0001)
    else $error("voltage step coarser than one count");

  ping_ok_c: cover property (state_q == wtvpc_pkg::st_ping ##1 state_q == wtvpc_pkg::st_xfer);
  retry_c:   cover property (state_q == wtvpc_pkg::st_off ##1 state_q == wtvpc_pkg::st_ping);
  fail_c:    cover property ($rose(fail_q));
  clamp_c:   cover property (state_q == wtvpc_pkg::st_xfer && err_valid_i &&
                             pid_c == wtvpc_pkg::PID_LIM);
  // Transfer reached through the second coil
  lower_coil_c: cover property (coil_q && state_q == wtvpc_pkg::st_xfer);

endmodule : wtvpc_top
`default_nettype wire

// >>> test/wtvpc_rx_model.sv
// Power receiver model: signal strength, control error and coil voltage reports
`default_nettype none
module wtvpc_rx_model #(
  parameter int          DLY     = 5,
  parameter logic [15:0] COIL_MV = 16'h1234
) (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  // Power stage seen across the link
  input  wire logic               power_en_i,
  input  wire logic               upper_i,
  input  wire logic               lower_i,
  // Scenario controls
  input  wire logic               ans_upper_i,
  input  wire logic               ans_lower_i,
  input  wire logic [7:0]         ss_level_i,
  input  wire logic               err_go_i,
  input  wire logic signed [15:0] err_amt_i,
  // Decoded reports
  output logic                    ss_valid_o,
  output logic      [7:0]         ss_value_o,
  output logic                    err_valid_o,
  output logic signed [15:0]      err_ma_o,
  output logic                    adc_valid_o,
  output logic      [15:0]        adc_mv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic       answer;

  // Only a powered, answering coil gives one packet per ping
  assign answer = power_en_i && (cnt_q == 8'(DLY)) &&
                  ((upper_i && ans_upper_i) || (lower_i && ans_lower_i));

  // Cycles since power came up, saturating so a ping answers once
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
    end else if (!power_en_i) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Reports; idle data lines toggle so stale values never look valid
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_valid_o  <= 1'b0;
      ss_value_o  <= 8'h00;
      err_valid_o <= 1'b0;
      err_ma_o    <= 16'sh0000;
      adc_valid_o <= 1'b0;
      adc_mv_o    <= 16'h0000;
    end else begin
      ss_valid_o  <= answer;
      ss_value_o  <= answer ? ss_level_i : ~ss_value_o;
      err_valid_o <= err_go_i;
      err_ma_o    <= err_go_i ? err_amt_i : ~err_ma_o;
      adc_valid_o <= power_en_i && (cnt_q[1:0] == 2'h0);
      adc_mv_o    <= (power_en_i && (cnt_q[1:0] == 2'h0)) ? COIL_MV : ~adc_mv_o;
    end
  end
endmodule : wtvpc_rx_model
`default_nettype wire

// >>> test/tb_top.sv
// Testbench: register access, ping retries, coil choice and voltage loop
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short ping and off times keep the run brief
  localparam logic [31:0] PING = 32'h00000014;
  localparam logic [31:0] OFFC = 32'h0000000a;
  localparam int LIM = int'(wtvpc_pkg::PID_LIM);
  localparam int VMX = int'(wtvpc_pkg::V_MAX);
  localparam int VMN = int'(wtvpc_pkg::V_MIN);
  logic               mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00, ss_lvl = 8'hff;
  logic [31:0]        pwdata = 32'h0, rd;
  logic               perr, err_go = 1'b0, ans_up = 1'b0, ans_lo = 1'b0;
  logic signed [15:0] err_amt = 16'sh0000;
  wire logic [31:0]   prdata;
  wire logic          pready, pslverr, ss_valid, err_valid, adc_valid, power_en, drive, up, lo;
  wire logic [7:0]    ss_value, freq;
  wire logic [15:0]   err_ma, adc_mv;
  wire logic [14:0]   vcmd;
  int                 mismatches = 0, check_count = 0, ev, f, per, hi;
  logic [7:0]  offs [5] = '{wtvpc_pkg::OFF_CTRL, wtvpc_pkg::OFF_SSMIN, wtvpc_pkg::OFF_STEP,
                            wtvpc_pkg::OFF_VCMD, wtvpc_pkg::OFF_FREQ};
  logic [31:0] rstv [5] = '{32'h0, 32'h1, 32'h5, 32'h3e80, 32'h8c};

  wtvpc_top #(.PING_CYC(PING), .OFF_CYC(OFFC)) u_wtvpc_top (
    .mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ss_valid_i(ss_valid), .ss_value_i(ss_value),
    .err_valid_i(err_valid), .err_ma_i(err_ma), .xfer_end_i(1'b0), .adc_valid_i(adc_valid),
    .adc_mv_i(adc_mv), .power_en_o(power_en), .drive_o(drive), .vcmd_o(vcmd),
    .freq_khz_o(freq), .upper_coil_switch_o(up), .lower_coil_switch_o(lo));

  wtvpc_rx_model u_wtvpc_rx_model (
    .mclk_i(mclk), .rst_n_i(rst_n), .power_en_i(power_en), .upper_i(up), .lower_i(lo),
    .ans_upper_i(ans_up), .ans_lower_i(ans_lo), .ss_level_i(ss_lvl), .err_go_i(err_go),
    .err_amt_i(err_amt), .ss_valid_o(ss_valid), .ss_value_o(ss_value),
    .err_valid_o(err_valid), .err_ma_o(err_ma), .adc_valid_o(adc_valid), .adc_mv_o(adc_mv));

  // 125 MHz clock
  always #4 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for a level on power enable or on the drive wave
  task automatic lvl(input logic drv, input logic v, output int n);
    n = 0;
    while ((drv ? drive : power_en) !== v && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : lvl

  task automatic wst(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, wtvpc_pkg::OFF_STATUS, 32'h0);
      n++;
    end while (rd[1:0] !== s && n < 100);
    if (n >= 100) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wst

  // Control error through the receiver, then the expected command
  task automatic pid(input int e);
    int c;
    c = (e > LIM) ? LIM : (e < -LIM) ? -LIM : e;
    c = ev - c;
    ev = (c > VMX) ? VMX : (c < VMN) ? VMN : c;
    @(posedge mclk);
    err_go <= 1'b1;
    err_amt <= 16'(e);
    @(posedge mclk);
    err_go <= 1'b0;
    repeat (3) @(posedge mclk);
    check(32'(vcmd), 32'(ev));
  endtask : pid

  // After a failed ping run: power off, fail flag set, then cleared
  task automatic fail_clear;
    repeat (OFFC + 5) @(posedge mclk);
    check(32'(power_en), 32'h0);
    apb(1'b0, wtvpc_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'hb, 32'h8);
    apb(1'b1, wtvpc_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, wtvpc_pkg::OFF_STATUS, 32'h8);
    apb(1'b0, wtvpc_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'h8, 32'h0);
  endtask : fail_clear

  // Coil switches must never both be open or both closed
  always @(posedge mclk) begin
    if (rst_n === 1'b1) check(32'(up ^ lo), 32'h1);
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    check(32'({power_en, up, lo}), 32'h2);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, offs[i], 32'h0);
      check(rd, rstv[i]);
    end
    apb(1'b1, 8'h1c, 32'hffffffff);
    check(32'(perr), 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    check({rd[30:0], perr}, 32'h1);
    apb(1'b1, wtvpc_pkg::OFF_FREQ, 32'h0);
    apb(1'b0, wtvpc_pkg::OFF_FREQ, 32'h0);
    check(rd, 32'h8c);
    // Fixed variant, answered ping, transfer and loop
    ans_up <= 1'b1;
    apb(1'b1, wtvpc_pkg::OFF_CTRL, 32'h1);
    lvl(1'b0, 1'b1, per);
    check(32'({vcmd, freq}), 32'({wtvpc_pkg::V_PING_FIX, wtvpc_pkg::F_FIX}));
    wst(2'h3);
    lvl(1'b1, 1'b0, per);
    lvl(1'b1, 1'b1, per);
    lvl(1'b1, 1'b0, per);
    lvl(1'b1, 1'b1, hi);
    check(32'((per + hi == 32'h37c) || (per + hi == 32'h37d)), 32'h1);
    ev = int'(wtvpc_pkg::V_PING_FIX);
    pid(32'h64);
    pid(32'h1);
    pid(32'h5dd);
    pid(-32'sh5dc);
    for (int i = 0; i < 8; i++) pid(-32'sh8000);
    for (int i = 0; i < 13; i++) pid(32'h7fff);
    apb(1'b0, wtvpc_pkg::OFF_VCMD, 32'h0);
    check(rd, 32'(ev));
    apb(1'b0, wtvpc_pkg::OFF_COILMV, 32'h0);
    check(rd, 32'h1234);
    apb(1'b1, wtvpc_pkg::OFF_CTRL, 32'h0);
    // Packet below the minimum counts as no answer
    ss_lvl <= 8'h40;
    apb(1'b1, wtvpc_pkg::OFF_SSMIN, 32'h80);
    apb(1'b1, wtvpc_pkg::OFF_CTRL, 32'h1);
    lvl(1'b0, 1'b1, per);
    lvl(1'b0, 1'b0, per);
    fail_clear();
    // Variable variant, silent receiver, retries down to the band edge
    ans_up <= 1'b0;
    apb(1'b1, wtvpc_pkg::OFF_STEP, 32'ha);
    apb(1'b1, wtvpc_pkg::OFF_CTRL, 32'h3);
    f = 140;
    for (int k = 0; k < 5; k++) begin
      lvl(1'b0, 1'b1, per);
      check(32'(freq), 32'(f));
      check(32'(vcmd), 32'(wtvpc_pkg::V_PING_VAR));
      lvl(1'b0, 1'b0, per);
      f = (f - 10 < 105) ? 105 : f - 10;
    end
    fail_clear();
    // Dual coil, only the lower coil answers, value at the minimum
    ss_lvl <= 8'h80;
    ans_lo <= 1'b1;
    apb(1'b1, wtvpc_pkg::OFF_CTRL, 32'h5);
    lvl(1'b0, 1'b1, per);
    check(32'({up, lo}), 32'h2);
    lvl(1'b0, 1'b0, per);
    lvl(1'b0, 1'b1, per);
    check(32'({up, lo}), 32'h1);
    wst(2'h3);
    check(rd & 32'h4, 32'h4);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
